// ---- fws_cyc_if.sv ----
`default_nettype none
interface fws_cyc_if;
   logic req;
   logic we;
   logic [21:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic done;
   modport eng (input req, we, addr, wdata, output rdata, done);
   modport ctl (output req, we, addr, wdata, input rdata, done);
endinterface
`default_nettype wire

// ---- fws_cycle.sv ----
`default_nettype none
module fws_cycle import fws_pkg::*; (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // request side
   fws_cyc_if.eng cyc,
   // flash pins
   output logic [21:0] addr_o,
   output logic [7:0] data_o,
   output logic data_oe_o,
   input wire logic [7:0] data_i,
   output logic ce_n_o,
   output logic oe_n_o,
   output logic we_n_o
);
   typedef enum logic [1:0] {
      C_IDLE = 2'b00, C_SETUP = 2'b01, C_STROBE = 2'b10, C_HOLD = 2'b11
   } fws_cst_e;
   fws_cst_e state, next_state;
   logic [3:0] cnt, next_cnt;
   logic wr, next_wr;
   logic [21:0] next_addr;
   logic [7:0] next_data, rdata, next_rdata;
   logic next_oe, next_ce_n, next_oe_n, next_we_n, done, next_done;
   logic [7:0] d1, d2, d3;

   assign cyc.rdata = rdata;
   assign cyc.done = done;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_wr = wr;
      next_addr = addr_o;
      next_data = data_o;
      next_rdata = rdata;
      next_oe = data_oe_o;
      next_ce_n = ce_n_o;
      next_oe_n = oe_n_o;
      next_we_n = we_n_o;
      next_done = 1'b0;
      case (state)
         C_IDLE: begin
            if (cyc.req) begin
               next_addr = cyc.addr;
               next_data = cyc.wdata;
               next_wr = cyc.we;
               next_oe = cyc.we;
               next_ce_n = 1'b0;
               next_state = C_SETUP;
            end
         end
         C_SETUP: begin
            next_oe_n = wr;
            next_we_n = ~wr;
            next_cnt = wr ? WP_CYC : ACC_CYC;
            next_state = C_STROBE;
         end
         C_STROBE: begin
            if (cnt > 4'h1) begin
               next_cnt = cnt - 4'h1;
            end else if (wr || d2 == d3) begin
               // sample only once two sync stages agree
               next_rdata = wr ? rdata : d3;
               next_oe_n = 1'b1;
               next_we_n = 1'b1;
               next_state = C_HOLD;
            end
         end
         C_HOLD: begin
            // raising chip enable and releasing the data bus closes the cycle
            next_ce_n = 1'b1;
            next_oe = 1'b0;
            next_done = 1'b1;
            next_state = C_IDLE;
         end
         default: next_state = C_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      d1 <= data_i;
      d2 <= d1;
      d3 <= d2;
      if (rst_i) begin
         state <= C_IDLE;
         cnt <= 4'h0;
         wr <= 1'b0;
         addr_o <= ADDR_RST;
         data_o <= DATA_RST;
         rdata <= DATA_RST;
         data_oe_o <= 1'b0;
         ce_n_o <= 1'b1;
         oe_n_o <= 1'b1;
         we_n_o <= 1'b1;
         done <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         wr <= next_wr;
         addr_o <= next_addr;
         data_o <= next_data;
         rdata <= next_rdata;
         data_oe_o <= next_oe;
         ce_n_o <= next_ce_n;
         oe_n_o <= next_oe_n;
         we_n_o <= next_we_n;
         done <= next_done;
      end
   end
endmodule
`default_nettype wire

// ---- fws_flash_model.sv ----
`default_nettype none
module fws_flash_model #(
   // command codes of this model only, values arbitrary
   parameter logic [7:0] SECTOR_CMD = 8'hA6,
   parameter logic [7:0] SUSPEND_CMD = 8'hB2,
   parameter int WINDOW_READS = 3
) (
   // pins from the host
   input wire logic [7:0] data_i,
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic reset_n_i,
   // data bus and open-drain busy
   output logic [7:0] dq_o,
   output logic rb_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int busy_reads = 0;
   int resets = 0;
   int window = 0;
   int sectors = 0;
   logic stuck = 1'b0, erase = 1'b0, tog1 = 1'b0, tog2 = 1'b0;
   logic suspend = 1'b0;
   logic [7:0] mem = 8'h5A, last = 8'h00, st;
   wire logic busy = busy_reads > 0 || stuck;
   assign rb_oe_o = busy && !suspend;
   always_comb begin
      st = mem;
      if (suspend) begin
         st = {1'b1, tog1, 3'h0, tog2, 2'h0};
      end else if (busy) begin
         st = {erase ? 1'b0 : ~mem[7], tog1, 6'h0};
         st[5] = stuck;
         st[3] = erase && window == 0;
         st[2] = tog2;
      end
   end
   // released bus shows the inverse so a stale byte never passes
   assign dq_o = (!ce_n_i && !oe_n_i) ? st : ~last;
   // the acceptance window is counted in reads: the model has no clock
   always @(negedge oe_n_i) begin
      if (!ce_n_i && (busy || suspend)) begin
         tog1 <= suspend ? tog1 : ~tog1;
         tog2 <= erase ? ~tog2 : tog2;
         if (window > 0) begin
            window <= window - 1;
         end else if (!stuck && !suspend) begin
            busy_reads <= busy_reads - 1;
         end
      end
   end
   always @(posedge oe_n_i) last <= st;
   always @(negedge reset_n_i) begin
      stuck <= 1'b0;
      suspend <= 1'b0;
      window <= 0;
      busy_reads <= 0;
   end
   always @(posedge we_n_i) begin
      if (!ce_n_i && data_i == 8'hF0) begin
         stuck <= 1'b0;
         busy_reads <= 0;
         resets <= resets + 1;
      end else if (!ce_n_i && erase && busy && data_i == SUSPEND_CMD) begin
         suspend <= ~suspend;
      end else if (!ce_n_i && busy) begin
         // past the window a late sector command is dropped
         if (data_i == SECTOR_CMD && window > 0) begin
            window <= WINDOW_READS;
            sectors <= sectors + 1;
         end
      end else if (!ce_n_i && data_i == SECTOR_CMD) begin
         erase <= 1'b1;
         window <= WINDOW_READS;
         busy_reads <= 4;
         sectors <= 1;
      end else if (!ce_n_i && |(data_i & ~mem)) begin
         stuck <= 1'b1;
      end else if (!ce_n_i) begin
         mem <= data_i;
         busy_reads <= 3;
      end
   end
endmodule
`default_nettype wire

// ---- fws_host.sv ----
`default_nettype none
module fws_host import fws_pkg::*; (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // flash pins
   output logic [21:0] flash_addr_o,
   output logic [7:0] flash_data_o,
   output logic flash_data_oe_o,
   input wire logic [7:0] flash_data_i,
   output logic flash_ce_n_o,
   output logic flash_oe_n_o,
   output logic flash_we_n_o,
   output logic flash_reset_n_o,
   input wire logic ready_busy_i
);
   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_SINGLE = 3'b001, S_RD1 = 3'b010, S_RD2 = 3'b011,
      S_RD3 = 3'b100, S_RD4 = 3'b101, S_FINAL = 3'b110, S_RST = 3'b111
   } fws_st_e;
   fws_st_e state, next_state;
   fws_cyc_if cyc ();
   logic req, next_req, we, next_we;
   logic [7:0] first, next_first, last, next_last, wd, next_wd;
   logic [21:0] addr, next_addr;
   logic done, next_done, fail, next_fail, hwrst, next_hwrst;
   logic ack, next_ack;
   logic reset_n;
   logic [31:0] dat, next_dat;
   logic rb1, rb2, rb3, ready, next_ready;
   logic wr_hit;

   assign cyc.req = req;
   assign cyc.we = we;
   assign cyc.addr = addr;
   assign cyc.wdata = we ? wd : DATA_RST;
   assign wb_ack_o = ack;
   assign wb_dat_o = dat;
   assign flash_reset_n_o = reset_n;
   assign wr_hit = wb_cyc_i & wb_stb_i & wb_we_i & ~ack & wb_sel_i[0];

   fws_cycle u_cycle (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cyc(cyc),
      .addr_o(flash_addr_o),
      .data_o(flash_data_o),
      .data_oe_o(flash_data_oe_o),
      .data_i(flash_data_i),
      .ce_n_o(flash_ce_n_o),
      .oe_n_o(flash_oe_n_o),
      .we_n_o(flash_we_n_o)
   );

   // register bus and ready/busy sync
   always_comb begin
      next_ack = wb_cyc_i & wb_stb_i & ~ack;
      next_dat = 32'h00000000;
      next_hwrst = hwrst;
      next_addr = addr;
      next_wd = wd;
      // ready only changes once the last two stages agree
      next_ready = (rb2 == rb3) ? rb3 : ready;
      if (wb_cyc_i && wb_stb_i && !ack && !wb_we_i) begin
         case (wb_adr_i)
            ADR_CTRL: next_dat[CTRL_HWRST_BIT] = hwrst;
            ADR_ADDR: next_dat[21:0] = addr;
            ADR_WDATA: next_dat[7:0] = wd;
            ADR_STAT: begin
               next_dat[7:0] = last;
               next_dat[STAT_BUSY_BIT] = state != S_IDLE;
               next_dat[STAT_DONE_BIT] = done;
               next_dat[STAT_FAIL_BIT] = fail;
               next_dat[STAT_READY_BIT] = ready;
               next_dat[STAT_ETMR_BIT] = last[ETMR_BIT];
            end
            default: next_dat = 32'h00000000;
         endcase
      end
      // address and data are locked while a command runs
      if (wr_hit && state == S_IDLE) begin
         case (wb_adr_i)
            ADR_CTRL: next_hwrst = wb_dat_i[CTRL_HWRST_BIT];
            ADR_ADDR: next_addr = wb_dat_i[21:0];
            ADR_WDATA: next_wd = wb_dat_i[7:0];
            default: next_wd = wd;
         endcase
      end
   end

   // command sequencer
   always_comb begin
      next_state = state;
      next_req = 1'b0;
      next_we = we;
      next_first = first;
      next_last = last;
      next_done = done;
      next_fail = fail;
      case (state)
         S_IDLE: begin
            if (wr_hit && wb_adr_i == ADR_CTRL && !hwrst &&
                wb_dat_i[1:0] != CMD_NONE) begin
               next_done = 1'b0;
               next_fail = 1'b0;
               next_req = 1'b1;
               next_we = wb_dat_i[1:0] == CMD_WRITE;
               // a new poll always begins with the full two-read check
               next_state = (wb_dat_i[1:0] == CMD_POLL) ?
                  S_RD1 : S_SINGLE;
            end
         end
         S_SINGLE: begin
            if (cyc.done) begin
               next_last = we ? last : cyc.rdata;
               next_done = 1'b1;
               next_state = S_IDLE;
            end
         end
         S_RD1, S_RD3: begin
            if (cyc.done) begin
               next_first = cyc.rdata;
               next_last = cyc.rdata;
               next_req = 1'b1;
               next_state = (state == S_RD1) ? S_RD2 : S_RD4;
            end
         end
         S_RD2: begin
            if (cyc.done) begin
               next_last = cyc.rdata;
               next_req = 1'b1;
               if (cyc.rdata[TOG1_BIT] == first[TOG1_BIT]) begin
                  next_state = S_FINAL;
               end else if (cyc.rdata[TMO_BIT]) begin
                  next_state = S_RD3;
               end else begin
                  next_state = S_RD1;
               end
            end
         end
         S_RD4: begin
            if (cyc.done) begin
               next_last = cyc.rdata;
               next_req = 1'b1;
               if (cyc.rdata[TOG1_BIT] == first[TOG1_BIT]) begin
                  next_state = S_FINAL;
               end else begin
                  next_fail = 1'b1;
                  next_we = 1'b1;
                  next_state = S_RST;
               end
            end
         end
         S_FINAL: begin
            // toggling stopped, so this read returns array data, or the suspend status byte while the device is suspended
            if (cyc.done) begin
               next_last = cyc.rdata;
               next_done = 1'b1;
               next_state = S_IDLE;
            end
         end
         S_RST: begin
            if (cyc.done) begin
               next_done = 1'b1;
               next_state = S_IDLE;
            end
         end
         default: next_state = S_IDLE;
      endcase
   end

   // the reset command goes out as write data with no sequencer copy
   always_ff @(posedge clk_i) begin
      rb1 <= ready_busy_i;
      rb2 <= rb1;
      rb3 <= rb2;
      if (rst_i) begin
         state <= S_IDLE;
         req <= 1'b0;
         we <= 1'b0;
         first <= DATA_RST;
         last <= DATA_RST;
         wd <= DATA_RST;
         addr <= ADDR_RST;
         done <= 1'b0;
         fail <= 1'b0;
         hwrst <= 1'b0;
         ack <= 1'b0;
         reset_n <= 1'b1;
         dat <= 32'h00000000;
         ready <= 1'b1;
      end else begin
         state <= next_state;
         req <= next_req;
         we <= next_we;
         first <= next_first;
         last <= next_last;
         wd <= (next_state == S_RST) ? RESET_CMD : next_wd;
         addr <= next_addr;
         done <= next_done;
         fail <= next_fail;
         hwrst <= next_hwrst;
         ack <= next_ack;
         reset_n <= ~next_hwrst;
         dat <= next_dat;
         ready <= next_ready;
      end
   end
endmodule
`default_nettype wire

// ---- fws_host_monitor.sv ----
`default_nettype none
module fws_host_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [21:0] flash_addr_o,
   input wire logic flash_data_oe_o,
   input wire logic flash_ce_n_o,
   input wire logic flash_oe_n_o,
   input wire logic flash_we_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   ack_reply_a: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   addr_hold_a: assert property (
      !flash_ce_n_o && $past(!flash_ce_n_o) |-> $stable(flash_addr_o))
      else $error("address moved in cycle");
   read_len_a: assert property (
      $fell(flash_oe_n_o) |-> !flash_oe_n_o [*5])
      else $error("read strobe short");
   write_len_a: assert property ($fell(flash_we_n_o) |->
      flash_data_oe_o && !flash_ce_n_o ##1 !flash_we_n_o ##1 flash_we_n_o)
      else $error("write strobe wrong");
   ce_close_a: assert property (
      $rose(flash_oe_n_o) || $rose(flash_we_n_o) |=> $rose(flash_ce_n_o))
      else $error("select not closed");
   bus_free_a: assert property (flash_data_oe_o |-> flash_oe_n_o)
      else $error("bus contention");
   reset_quiet_a: assert property (disable iff (1'b0) rst_i |=>
      flash_ce_n_o && flash_oe_n_o && flash_we_n_o && !wb_ack_o)
      else $error("pins active in reset");
endmodule
bind fws_host fws_host_monitor mon (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .flash_addr_o(flash_addr_o), .flash_data_oe_o(flash_data_oe_o),
   .flash_ce_n_o(flash_ce_n_o), .flash_oe_n_o(flash_oe_n_o),
   .flash_we_n_o(flash_we_n_o));
`default_nettype wire

// ---- fws_pkg.sv ----
`default_nettype none
package fws_pkg;
   // wishbone register byte offsets
   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_ADDR = 4'h4;
   localparam logic [3:0] ADR_WDATA = 4'h8;
   localparam logic [3:0] ADR_STAT = 4'hC;
   // command codes in ctrl[1:0]
   localparam logic [1:0] CMD_NONE = 2'h0;
   localparam logic [1:0] CMD_WRITE = 2'h1;
   localparam logic [1:0] CMD_READ = 2'h2;
   localparam logic [1:0] CMD_POLL = 2'h3;
   localparam int CTRL_HWRST_BIT = 7;
   // status field positions
   localparam int STAT_BUSY_BIT = 8;
   localparam int STAT_DONE_BIT = 9;
   localparam int STAT_FAIL_BIT = 10;
   localparam int STAT_READY_BIT = 11;
   localparam int STAT_ETMR_BIT = 12;
   // status bits on the flash data bus
   localparam int POLL_BIT = 7;
   localparam int TOG1_BIT = 6;
   localparam int TMO_BIT = 5;
   localparam int ETMR_BIT = 3;
   localparam int TOG2_BIT = 2;
   localparam logic [7:0] RESET_CMD = 8'hF0;
   // reset values
   localparam logic [21:0] ADDR_RST = 22'h000000;
   localparam logic [7:0] DATA_RST = 8'h00;
   // timing
   localparam int CLK_NS = 40;
   localparam int T_ACC_NS = 100;
   localparam int T_WP_NS = 50;
   localparam int SYNC_CYC = 2;
   localparam logic [3:0] ACC_CYC =
      4'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
   localparam logic [3:0] WP_CYC = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
endpackage
`default_nettype wire

// ---- tb_fws_host.sv ----
`default_nettype none
module tb_fws_host import fws_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic chk = 1'b0, ack, rb_oe, foe, ce_n, oe_n, we_n, rst_n;
   logic [3:0] adr = 4'h0;
   logic [31:0] dat = 32'h0, rd, rdat;
   logic [21:0] fa;
   logic [7:0] fdo, dq;
   logic [63:0] q[$];
   logic [63:0] e;
   int n_errors = 0, cmp_count = 0, cyc_n = 0;
   fws_host uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .flash_addr_o(fa),
      .flash_data_o(fdo), .flash_data_oe_o(foe), .flash_data_i(dq),
      .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n),
      .flash_reset_n_o(rst_n), .ready_busy_i(~rb_oe));
   // command codes shared with the model, values arbitrary
   localparam logic [7:0] SECTOR_CMD = 8'hA6;
   localparam logic [7:0] SUSPEND_CMD = 8'hB2;
   fws_flash_model #(.SECTOR_CMD(SECTOR_CMD), .SUSPEND_CMD(SUSPEND_CMD))
      fm (.data_i(fdo), .ce_n_i(ce_n), .oe_n_i(oe_n),
      .we_n_i(we_n), .reset_n_i(rst_n), .dq_o(dq), .rb_oe_o(rb_oe));
   initial forever #20 clk_i = ~clk_i;
   task automatic tally_and_finish();
      if (n_errors == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 30000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   always @(posedge clk_i) begin
      if (ack && chk) begin
         e = q.pop_front();
         cmp_count++;
         if ((rdat & e[63:32]) !== e[31:0]) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, rdat,
               e[31:0]);
         end
      end
   end
   task automatic wb(input logic w, input logic [3:0] a,
      input logic [31:0] d, input logic c);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; chk <= c;
      do @(posedge clk_i); while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0; stb <= 1'b0; chk <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, v);
      q.push_back({m, v});
      wb(1'b0, a, 32'h0, 1'b1);
   endtask
   task automatic cmd(input logic [1:0] c);
      wb(1'b1, ADR_CTRL, {30'h0, c}, 1'b0);
      do wb(1'b0, ADR_STAT, 32'h0, 1'b0); while (rd[STAT_DONE_BIT] !== 1'b1);
   endtask
   initial begin
      logic [7:0] d;
      logic [21:0] a;
      int r0;
      void'($urandom(32'h4420E75E));
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(ADR_STAT, 32'h1F00, 32'h800);
      rd_chk(4'h2, 32'hFFFFFFFF, 32'h0);
      for (int i = 0; i < 4; i++) begin
         a = 22'($urandom);
         d = 8'($urandom) & fm.mem;
         wb(1'b1, ADR_ADDR, {10'h0, a}, 1'b0);
         rd_chk(ADR_ADDR, 32'h3FFFFF, {10'h0, a});
         wb(1'b1, ADR_WDATA, {24'h0, d}, 1'b0);
         cmd(CMD_WRITE);
         // long busy spells force the two-read check to restart
         fm.busy_reads = 1 + i * 3;
         fm.erase = i[0];
         cmd(CMD_POLL);
         rd_chk(ADR_STAT, 32'h7FF, {21'h0, 3'b010, d});
      end
      r0 = fm.resets;
      wb(1'b1, ADR_WDATA, {24'h0, ~fm.mem}, 1'b0);
      cmd(CMD_WRITE);
      cmd(CMD_POLL);
      rd_chk(ADR_STAT, 32'h700, 32'h600);
      cmp_count++;
      if (fm.resets != r0 + 1 || fm.stuck !== 1'b0) begin
         n_errors++;
         $display("wrong value at %0t: no reset command", $time);
      end
      // second sector command lands inside the window and restarts it
      wb(1'b1, ADR_WDATA, {24'h0, SECTOR_CMD}, 1'b0);
      cmd(CMD_WRITE);
      cmd(CMD_READ);
      rd_chk(ADR_STAT, 32'h1000, 32'h0);
      cmd(CMD_WRITE);
      cmd(CMD_READ);
      cmd(CMD_READ);
      rd_chk(ADR_STAT, 32'h1000, 32'h0);
      cmd(CMD_READ);
      rd_chk(ADR_STAT, 32'h1000, 32'h1000);
      cmd(CMD_WRITE);
      cmp_count++;
      if (fm.sectors != 2) begin
         n_errors++;
         $display("wrong value at %0t: late sector taken", $time);
      end
      wb(1'b1, ADR_WDATA, {24'h0, SUSPEND_CMD}, 1'b0);
      cmd(CMD_WRITE);
      cmd(CMD_POLL);
      rd_chk(ADR_STAT, 32'h8B8, 32'h880);
      cmd(CMD_WRITE);
      cmd(CMD_READ);
      rd_chk(ADR_STAT, 32'h8A8, 32'h008);
      cmd(CMD_POLL);
      rd_chk(ADR_STAT, 32'h700, 32'h200);
      wb(1'b1, ADR_CTRL, 32'h80, 1'b0);
      cmp_count++;
      if (rst_n !== 1'b0) begin
         n_errors++;
         $display("wrong value at %0t: reset pin not driven", $time);
      end
      wb(1'b1, ADR_CTRL, 32'h82, 1'b0);
      rd_chk(ADR_STAT, 32'h100, 32'h0);
      rd_chk(ADR_CTRL, 32'h80, 32'h80);
      wb(1'b1, ADR_CTRL, 32'h0, 1'b0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
